// ---- hw/srr_status_regs.sv ----
/*
  Operation and questionable status register groups for one channel,
  with condition, event latch and enable mask per group and the two
  status byte summary bits. Assumes one command per srr_cmd_t pulse
  from the command parser, and live flags from the analog side.
*/
// Notes on behaviour
// - Operation condition follows regulation state live
// - Bit 10 current regulation, bit 8 voltage
// - Operation values stay within zero to 1313
// - One means active, zero means inactive
// - Bit 7 ORs enabled operation events
// - Operation enable mask reads back unchanged
// - Operation event latch read-only, holds events
// - Reading operation events returns then clears
// - Preset zeroes both condition registers
// - Bit 13 current error, bit 12 voltage
// - Bit 1 current mode, bit 0 voltage
// - Only error bits latch as questionable events
// - Questionable events read-only, clear on read
// - Bit 3 ORs enabled questionable events
// - Both mode bits may be set together
module srr_status_regs #(
  parameter int unsigned REG_W = 16
) (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              srst,
  // Host command port
  input  wire logic              cmd_valid,
  input  wire srr_pkg::srr_cmd_t cmd,
  output logic                   rsp_valid,
  output logic [REG_W-1:0]       rsp_data,
  output logic                   cmd_refused,
  // Live regulation flags
  input  wire srr_pkg::srr_live_t live_flags,
  // Status byte summaries
  output logic                   op_summary,
  output logic                   ques_summary,
  output logic [7:0]             status_summary
);
  import srr_pkg::*;

  if (REG_W != SRR_REG_W) begin : g_bad_width
    $error("srr_status_regs: REG_W must equal SRR_REG_W");
  end

  // Flag synchroniser: s1 feeds s2 only
  logic [LIVE_W-1:0] sync1_r, sync2_r, sync3_r, stable_r;
  logic [LIVE_W-1:0] sync1_nxt, sync2_nxt, sync3_nxt, stable_nxt;
  srr_live_t         live_s;

  always_comb begin
    sync1_nxt  = live_flags;
    sync2_nxt  = sync1_r;
    sync3_nxt  = sync2_r;
    // A change counts once the second and third stage agree
    stable_nxt = (~(sync2_r ^ sync3_r) & sync2_r) | ((sync2_r ^ sync3_r) & stable_r);
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sync1_r  <= '0;
      sync2_r  <= '0;
      sync3_r  <= '0;
      stable_r <= '0;
    end else begin
      sync1_r  <= sync1_nxt;
      sync2_r  <= sync2_nxt;
      sync3_r  <= sync3_nxt;
      stable_r <= stable_nxt;
    end
  end

  assign live_s = srr_live_t'(stable_r);

  // Command decode
  function automatic logic is_cmd(input logic v, input srr_cmd_t c, input srr_cmd_op_t o);
    is_cmd = v && (c.op == o);
  endfunction : is_cmd

  logic preset_cmd, rd_op_evt, rd_qs_evt;
  assign preset_cmd = is_cmd(cmd_valid, cmd, SRR_PRESET);
  assign rd_op_evt  = is_cmd(cmd_valid, cmd, SRR_RD_OP_EVT);
  assign rd_qs_evt  = is_cmd(cmd_valid, cmd, SRR_RD_QS_EVT);

  // Register state
  logic [REG_W-1:0] op_cond_r, op_en_r, op_evt_r, qs_cond_r, qs_en_r, qs_evt_r;
  logic [REG_W-1:0] op_cond_nxt, op_en_nxt, op_evt_nxt, qs_cond_nxt, qs_en_nxt, qs_evt_nxt;
  logic [REG_W-1:0] op_live, qs_live;
  logic [REG_W-1:0] rsp_data_nxt;
  logic             rsp_valid_nxt, refused_nxt, op_sum_nxt, qs_sum_nxt;
  logic             op_sum_r, qs_sum_r, rsp_valid_r, refused_r;
  logic [REG_W-1:0] rsp_data_r;

  always_comb begin
    op_live = REG_ZERO;
    qs_live = REG_ZERO;
    op_live[OP_CURR_REG_BIT]  = live_s.current_regulation_flag;
    op_live[OP_VOLT_REG_BIT]  = live_s.voltage_regulation_flag;
    qs_live[QS_CURR_ERR_BIT]  = live_s.current_error_flag;
    qs_live[QS_VOLT_ERR_BIT]  = live_s.voltage_error_flag;
    // Both mode bits pass independently, settling shows both set
    qs_live[QS_CURR_MODE_BIT] = live_s.current_mode_indicator;
    qs_live[QS_VOLT_MODE_BIT] = live_s.voltage_mode_indicator;

    // Preset blanks conditions for one cycle; they then follow again
    op_cond_nxt = preset_cmd ? REG_ZERO : op_live;
    qs_cond_nxt = preset_cmd ? REG_ZERO : qs_live;

    // New rising edge wins over a clear in the same cycle
    op_evt_nxt = (rd_op_evt ? REG_ZERO : op_evt_r)
               | (op_cond_nxt & ~op_cond_r & OP_LATCH_MASK);
    qs_evt_nxt = (rd_qs_evt ? REG_ZERO : qs_evt_r)
               | (qs_cond_nxt & ~qs_cond_r & QS_LATCH_MASK);

    op_en_nxt     = op_en_r;
    qs_en_nxt     = qs_en_r;
    rsp_valid_nxt = 1'b0;
    rsp_data_nxt  = REG_ZERO;
    refused_nxt   = 1'b0;
    if (cmd_valid) begin
      unique case (cmd.op)
        SRR_RD_OP_COND: begin
          rsp_valid_nxt = 1'b1;
          rsp_data_nxt  = op_cond_r;
        end
        SRR_RD_OP_EN: begin
          rsp_valid_nxt = 1'b1;
          rsp_data_nxt  = op_en_r;
        end
        SRR_WR_OP_EN: begin
          // Out-of-range mask refused, old mask kept
          if (cmd.data <= OP_VALUE_MAX) begin
            op_en_nxt = cmd.data;
          end else begin
            refused_nxt = 1'b1;
          end
        end
        SRR_RD_OP_EVT: begin
          rsp_valid_nxt = 1'b1;
          rsp_data_nxt  = op_evt_r;
        end
        SRR_RD_QS_COND: begin
          rsp_valid_nxt = 1'b1;
          rsp_data_nxt  = qs_cond_r;
        end
        SRR_RD_QS_EN: begin
          rsp_valid_nxt = 1'b1;
          rsp_data_nxt  = qs_en_r;
        end
        SRR_WR_QS_EN: begin
          qs_en_nxt = cmd.data;
        end
        SRR_RD_QS_EVT: begin
          rsp_valid_nxt = 1'b1;
          rsp_data_nxt  = qs_evt_r;
        end
        SRR_PRESET: begin
          rsp_valid_nxt = 1'b0;
        end
        SRR_WR_OP_COND, SRR_WR_OP_EVT, SRR_WR_QS_COND, SRR_WR_QS_EVT: begin
          refused_nxt = 1'b1;
        end
        // Codes past the command set are refused, nothing changes
        default: begin
          refused_nxt = 1'b1;
        end
      endcase
    end

    // Summaries track the registers they are built from
    op_sum_nxt = |(op_evt_nxt & op_en_nxt);
    qs_sum_nxt = |(qs_evt_nxt & qs_en_nxt);
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      op_cond_r   <= REG_ZERO;
      op_en_r     <= EN_RESET;
      op_evt_r    <= REG_ZERO;
      qs_cond_r   <= REG_ZERO;
      qs_en_r     <= EN_RESET;
      qs_evt_r    <= REG_ZERO;
      rsp_valid_r <= 1'b0;
      rsp_data_r  <= REG_ZERO;
      refused_r   <= 1'b0;
      op_sum_r    <= 1'b0;
      qs_sum_r    <= 1'b0;
    end else begin
      op_cond_r   <= op_cond_nxt;
      op_en_r     <= op_en_nxt;
      op_evt_r    <= op_evt_nxt;
      qs_cond_r   <= qs_cond_nxt;
      qs_en_r     <= qs_en_nxt;
      qs_evt_r    <= qs_evt_nxt;
      rsp_valid_r <= rsp_valid_nxt;
      rsp_data_r  <= rsp_data_nxt;
      refused_r   <= refused_nxt;
      op_sum_r    <= op_sum_nxt;
      qs_sum_r    <= qs_sum_nxt;
    end
  end

  assign rsp_valid    = rsp_valid_r;
  assign rsp_data     = rsp_data_r;
  assign cmd_refused  = refused_r;
  assign op_summary   = op_sum_r;
  assign ques_summary = qs_sum_r;

  always_comb begin
    status_summary = 8'h00;
    status_summary[SB_OP_SUM_BIT] = op_sum_r;
    status_summary[SB_QS_SUM_BIT] = qs_sum_r;
  end

  // Checks
  chk_op_cond_live: assert property (@(posedge ref_clk) disable iff (srst)
    !$past(preset_cmd) |-> op_cond_r[OP_CURR_REG_BIT] == $past(stable_r[LIVE_W-1]))
    else $error("operation condition does not follow current regulation");

  chk_op_unused_zero: assert property (@(posedge ref_clk) disable iff (srst)
    (op_cond_r & ~OP_LATCH_MASK) == REG_ZERO)
    else $error("unused operation condition bit set");

  chk_op_rsp_range: assert property (@(posedge ref_clk) disable iff (srst)
    $rose(rsp_valid_r) && $past(cmd.op) != SRR_RD_QS_EN && $past(cmd.op) != SRR_RD_QS_EVT
      && $past(cmd.op) != SRR_RD_QS_COND |-> rsp_data_r <= OP_VALUE_MAX)
    else $error("operation value out of range");

  chk_op_summary: assert property (@(posedge ref_clk) disable iff (srst)
    op_summary == |(op_evt_r & op_en_r))
    else $error("operation summary mismatch");

  chk_op_en_readback: assert property (@(posedge ref_clk) disable iff (srst)
    is_cmd(cmd_valid, cmd, SRR_WR_OP_EN) && cmd.data <= OP_VALUE_MAX ##1
      is_cmd(cmd_valid, cmd, SRR_RD_OP_EN) |=> rsp_valid && rsp_data == $past(cmd.data, 2))
    else $error("operation enable does not read back");

  chk_op_evt_hold: assert property (@(posedge ref_clk) disable iff (srst)
    !$past(rd_op_evt) |-> (op_evt_r & $past(op_evt_r)) == $past(op_evt_r))
    else $error("operation event lost without a read");

  chk_op_evt_clear: assert property (@(posedge ref_clk) disable iff (srst)
    rd_op_evt && op_cond_r == op_live |=> rsp_data == $past(op_evt_r) && op_evt_r == REG_ZERO)
    else $error("operation event read did not clear");

  chk_preset_zero: assert property (@(posedge ref_clk) disable iff (srst)
    preset_cmd |=> op_cond_r == REG_ZERO && qs_cond_r == REG_ZERO)
    else $error("preset did not zero conditions");

  chk_qs_latch_only: assert property (@(posedge ref_clk) disable iff (srst)
    (qs_evt_r & ~QS_LATCH_MASK) == REG_ZERO)
    else $error("non-error bit latched as questionable event");

  chk_qs_summary: assert property (@(posedge ref_clk) disable iff (srst)
    ques_summary == |(qs_evt_r & qs_en_r))
    else $error("questionable summary mismatch");

  chk_evt_on_rise: assert property (@(posedge ref_clk) disable iff (srst)
    $rose(qs_cond_r[QS_CURR_ERR_BIT]) |-> qs_evt_r[QS_CURR_ERR_BIT])
    else $error("rising current error not latched");

  chk_write_ignored: assert property (@(posedge ref_clk) disable iff (srst)
    is_cmd(cmd_valid, cmd, SRR_WR_OP_EVT) && !rd_op_evt && op_cond_r == op_live
      |=> op_evt_r == $past(op_evt_r) && cmd_refused)
    else $error("event write was not ignored");

endmodule : srr_status_regs

// ---- include/srr_pkg.sv ----
/*
  Shared constants and types for the status reporting registers of one
  output channel: bit positions, value limits, command set and carriers.
  Assumes the command decoder turns each host status command into one
  srr_cmd_t and the regulation loop supplies the live flags as levels.
*/
package srr_pkg;

  localparam int unsigned SRR_REG_W = 16;

  // Operation group bit positions
  localparam int unsigned OP_CURR_REG_BIT = 10;
  localparam int unsigned OP_VOLT_REG_BIT = 8;
  // Questionable group bit positions
  localparam int unsigned QS_CURR_ERR_BIT = 13;
  localparam int unsigned QS_VOLT_ERR_BIT = 12;
  localparam int unsigned QS_CURR_MODE_BIT = 1;
  localparam int unsigned QS_VOLT_MODE_BIT = 0;
  // Status byte summary positions
  localparam int unsigned SB_OP_SUM_BIT = 7;
  localparam int unsigned SB_QS_SUM_BIT = 3;

  // Largest legal value of the operation registers (sum of weights)
  localparam logic [15:0] OP_VALUE_MAX = 16'h0521;
  // Only the error flags may reach the questionable event latch
  localparam logic [15:0] QS_LATCH_MASK = 16'h3000;
  localparam logic [15:0] OP_LATCH_MASK = 16'h0500;
  localparam logic [15:0] REG_ZERO      = 16'h0000;
  localparam logic [15:0] EN_RESET      = 16'h0000;

  typedef enum logic [3:0] {
    SRR_RD_OP_COND,
    SRR_RD_OP_EN,
    SRR_WR_OP_EN,
    SRR_RD_OP_EVT,
    SRR_RD_QS_COND,
    SRR_RD_QS_EN,
    SRR_WR_QS_EN,
    SRR_RD_QS_EVT,
    SRR_PRESET,
    SRR_WR_OP_COND,
    SRR_WR_OP_EVT,
    SRR_WR_QS_COND,
    SRR_WR_QS_EVT
  } srr_cmd_op_t;

  typedef struct packed {
    srr_cmd_op_t op;
    logic [15:0] data;
  } srr_cmd_t;

  // Live flags from the regulation loop, asynchronous to ref_clk
  typedef struct packed {
    logic current_regulation_flag;
    logic voltage_regulation_flag;
    logic current_error_flag;
    logic voltage_error_flag;
    logic current_mode_indicator;
    logic voltage_mode_indicator;
  } srr_live_t;

  localparam int unsigned LIVE_W = $bits(srr_live_t);

endpackage : srr_pkg

// ---- tb/srr_host_model.sv ----
/*
  Remote host model: issues one status command or query at a time.
  Assumes the device answers on the same edge that takes a command.
*/
module srr_host_model
  import srr_pkg::*;
(
  // Clock
  input  wire logic        ref_clk,
  // Command port
  output logic             cmd_valid,
  output srr_cmd_t         cmd,
  input  wire logic        rsp_valid,
  input  wire logic [15:0] rsp_data,
  input  wire logic        cmd_refused
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    cmd_valid = 1'b0;
    cmd       = '{op: SRR_RD_OP_COND, data: 16'hA5A5};
  end

  // Held a full cycle; answer sampled once the taking edge has landed
  task automatic do_cmd(input srr_cmd_op_t op, input logic [15:0] data,
                        output logic rv, output logic [15:0] rd, output logic rf);
    @(negedge ref_clk);
    cmd_valid = 1'b1;
    cmd       = '{op: op, data: data};
    @(negedge ref_clk);
    rv        = rsp_valid;
    rd        = rsp_data;
    rf        = cmd_refused;
    cmd_valid = 1'b0;
    // Released data is inverted so a stale value never looks valid
    cmd.data  = ~data;
  endtask : do_cmd

  // Two commands on consecutive edges; only the second one's answer is taken
  task automatic do_pair(input srr_cmd_t c1, input srr_cmd_t c2,
                         output logic rv, output logic [15:0] rd);
    @(negedge ref_clk);
    cmd_valid = 1'b1;
    cmd       = c1;
    @(negedge ref_clk);
    cmd       = c2;
    @(negedge ref_clk);
    rv        = rsp_valid;
    rd        = rsp_data;
    cmd_valid = 1'b0;
    cmd.data  = ~c2.data;
  endtask : do_pair
endmodule : srr_host_model

// ---- tb/tb.sv ----
/*
  Self-checking bench for the status reporting registers.
  Assumes the host model drives the command port; live flags come from here.
*/
module tb
  import srr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic ref_clk, srst, cmd_valid, rsp_valid, cmd_refused, op_summary, ques_summary;
  srr_cmd_t    cmd;
  logic [15:0] rsp_data;
  srr_live_t   live_flags;
  logic [7:0]  status_summary;
  int num_errors = 0;
  int n_tests = 0;

  srr_status_regs dut_u (.ref_clk(ref_clk), .srst(srst), .cmd_valid(cmd_valid), .cmd(cmd),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .cmd_refused(cmd_refused), .live_flags(live_flags),
    .op_summary(op_summary), .ques_summary(ques_summary), .status_summary(status_summary));
  srr_host_model host_u (.ref_clk(ref_clk), .cmd_valid(cmd_valid), .cmd(cmd), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .cmd_refused(cmd_refused));

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic rd(input srr_cmd_op_t op, input logic [15:0] exp);
    logic v, f;
    logic [15:0] d;
    host_u.do_cmd(op, 16'h0000, v, d, f);
    check({15'h0000, v}, 16'h0001);
    check(d, exp);
  endtask : rd

  task automatic wr(input srr_cmd_op_t op, input logic [15:0] data, input logic refused);
    logic v, f;
    logic [15:0] d;
    host_u.do_cmd(op, data, v, d, f);
    check({15'h0000, f}, {15'h0000, refused});
    check({15'h0000, v}, 16'h0000);
  endtask : wr

  // Back-to-back pair; the second command must be a query
  task automatic pair_rd(input srr_cmd_op_t op1, input logic [15:0] data1, input srr_cmd_op_t op2,
                         input logic [15:0] exp);
    logic v;
    logic [15:0] d;
    host_u.do_pair(srr_cmd_t'{op: op1, data: data1}, srr_cmd_t'{op: op2, data: 16'h0000}, v, d);
    check({15'h0000, v}, 16'h0001);
    check(d, exp);
  endtask : pair_rd

  // Synchroniser plus condition update needs five edges; eight is margin
  task automatic flags(input logic [5:0] val);
    @(negedge ref_clk);
    live_flags = val;
    repeat (8) @(negedge ref_clk);
  endtask : flags

  task automatic sums(input logic [1:0] exp);
    check({14'h0000, op_summary, ques_summary}, {14'h0000, exp});
    check({8'h00, status_summary}, {8'h00, exp[1], 3'h0, exp[0], 3'h0});
  endtask : sums

  task automatic t_reset;
    rd(SRR_RD_OP_COND, 16'h0000);
    rd(SRR_RD_OP_EN, 16'h0000);
    rd(SRR_RD_OP_EVT, 16'h0000);
    rd(SRR_RD_QS_COND, 16'h0000);
    rd(SRR_RD_QS_EN, 16'h0000);
    rd(SRR_RD_QS_EVT, 16'h0000);
    sums(2'b00);
  endtask : t_reset

  task automatic t_op_enable;
    wr(SRR_WR_OP_EN, 16'h0500, 1'b0);
    rd(SRR_RD_OP_EN, 16'h0500);
    wr(SRR_WR_OP_EN, OP_VALUE_MAX, 1'b0);
    rd(SRR_RD_OP_EN, 16'h0521);
    wr(SRR_WR_OP_EN, 16'h0522, 1'b1);
    rd(SRR_RD_OP_EN, 16'h0521);
    pair_rd(SRR_WR_OP_EN, 16'h0500, SRR_RD_OP_EN, 16'h0500);
    wr(SRR_WR_OP_EN, 16'h0400, 1'b0);
  endtask : t_op_enable

  task automatic t_op_group;
    flags(6'b010000);
    rd(SRR_RD_OP_COND, 16'h0100);
    sums(2'b00);
    flags(6'b110000);
    rd(SRR_RD_OP_COND, 16'h0500);
    sums(2'b10);
    rd(SRR_RD_OP_EVT, 16'h0500);
    rd(SRR_RD_OP_EVT, 16'h0000);
    sums(2'b00);
    flags(6'b000000);
    rd(SRR_RD_OP_COND, 16'h0000);
  endtask : t_op_group

  task automatic t_ques_group;
    wr(SRR_WR_QS_EN, QS_LATCH_MASK, 1'b0);
    flags(6'b001011);
    rd(SRR_RD_QS_COND, 16'h2003);
    sums(2'b01);
    rd(SRR_RD_QS_EN, 16'h3000);
    rd(SRR_RD_QS_EVT, 16'h2000);
    rd(SRR_RD_QS_EVT, 16'h0000);
    flags(6'b000100);
    rd(SRR_RD_QS_COND, 16'h1000);
    rd(SRR_RD_QS_EVT, 16'h1000);
  endtask : t_ques_group

  task automatic t_refuse;
    srr_cmd_op_t ops[4] = '{SRR_WR_OP_COND, SRR_WR_OP_EVT, SRR_WR_QS_COND, SRR_WR_QS_EVT};
    foreach (ops[i]) wr(ops[i], 16'h0100, 1'b1);
    rd(SRR_RD_QS_COND, 16'h1000);
    rd(SRR_RD_OP_EVT, 16'h0000);
  endtask : t_refuse

  // Flags stay active, so a preset shows up as freshly latched events
  task automatic t_preset;
    flags(6'b100100);
    rd(SRR_RD_OP_EVT, 16'h0400);
    rd(SRR_RD_QS_EVT, 16'h0000);
    pair_rd(SRR_PRESET, 16'h0000, SRR_RD_QS_COND, 16'h0000);
    pair_rd(SRR_PRESET, 16'h0000, SRR_RD_OP_COND, 16'h0000);
    wr(SRR_PRESET, 16'h0000, 1'b0);
    repeat (3) @(negedge ref_clk);
    rd(SRR_RD_OP_EVT, 16'h0400);
    rd(SRR_RD_QS_EVT, 16'h1000);
  endtask : t_preset

  task automatic wrap_up;
    $display("checks=%0d errors=%0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (3000) @(posedge ref_clk);
    num_errors++;
    wrap_up();
  end

  initial begin
    srst       = 1'b1;
    live_flags = '0;
    repeat (8) @(negedge ref_clk);
    srst = 1'b0;
    t_reset();
    t_op_enable();
    t_op_group();
    t_ques_group();
    t_refuse();
    t_preset();
    wrap_up();
  end
endmodule : tb
